// ---- bench/tsm_station_model.sv ----
// four test stations: start buttons and auto/manual switches
`timescale 1ns/1ps
module tsm_station_model (
	input  wire       i_core_clk,
	output reg  [3:0] o_start_req,
	output reg  [3:0] o_manual_sw
);
	initial o_start_req = 4'h0;
	initial o_manual_sw = 4'h0;
	// start is a level held long enough to cross the input synchroniser
	task press(input int n);
		o_start_req[n] <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		o_start_req[n] <= 1'b0;
		@(posedge i_core_clk);
	endtask
endmodule // tsm_station_model

// ---- bench/tsm_station_mux_sva.sv ----
// checker for the station multiplexer ports
`timescale 1ns/1ps
`include "tsm_defines.vh"
module tsm_station_mux_sva (
	input wire                    i_core_clk,
	input wire                    i_resetn,
	input wire                    i_psel,
	input wire                    i_penable,
	input wire                    i_pwrite,
	input wire [`TSM_ADDR_W-1:0]  i_paddr,
	input wire [31:0]             i_pwdata,
	input wire [`TSM_NSTA-1:0]    o_station_enable,
	input wire [`TSM_LONG_W-1:0]  o_long_data,
	input wire [`TSM_NSTA-1:0]    o_long_strobe,
	input wire [`TSM_NSTA-1:0]    o_analog_connect
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	wire wr = i_psel & i_penable & i_pwrite;
	wire wsel = wr && i_paddr == `TSM_ADDR_SEL;
	wire wlong = wr && i_paddr == `TSM_ADDR_INSTR;
	wire [3:0] en = o_station_enable;
	property p_onehot; $onehot0(en); endproperty
	a_onehot: assert property (p_onehot) else $error("enable not one-hot");
	property p_decode; wsel |-> ##2 en == 4'h1 << $past(i_pwdata[1:0], 2); endproperty
	a_decode: assert property (p_decode) else $error("bad decode");
	property p_hold; !$stable(en) |-> $past(wsel, 2) || $past(wsel); endproperty
	a_hold: assert property (p_hold) else $error("enable moved");
	property p_rst; $rose(i_resetn) |-> en == 4'h0 && o_analog_connect == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("enable after reset");
	property p_analog; (o_analog_connect & ~(en | $past(en))) == 4'h0; endproperty
	a_analog: assert property (p_analog) else $error("analog leak");
	property p_strb; (o_long_strobe & ~en) == 4'h0; endproperty
	a_strb: assert property (p_strb) else $error("strobe leak");
	property p_pulse; wlong |=> o_long_strobe == en ##1 o_long_strobe == 4'h0; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe pulse");
	property p_ldata; wlong |=> o_long_data == $past(i_pwdata[23:0]); endproperty
	a_ldata: assert property (p_ldata) else $error("long data");
	c_sel: cover property (wsel ##2 en != 4'h0);
	c_long: cover property (wlong ##1 o_long_strobe != 4'h0);
	c_analog: cover property (o_analog_connect != 4'h0);
endmodule // tsm_station_mux_sva
bind tsm_station_mux tsm_station_mux_sva tsm_station_mux_sva_inst (.*);

// ---- bench/tsm_station_mux_tb.sv ----
// register level tests of the station multiplexer
`timescale 1ns/1ps
`include "tsm_defines.vh"
module tsm_station_mux_tb;
	reg clk = 0, rstn = 0, psel = 0, pen = 0, pw = 0, asel = 1, qe;
	reg [11:0] pa = 12'h000;
	reg [31:0] pwd = 32'h0, q, pend;
	wire [31:0] prd;
	wire rdy, err;
	wire [3:0] st, man, en, strb, ana;
	wire [23:0] ld, sr;
	int failures = 0, total_checks = 0, k, p;
	initial forever #2.5 clk = ~clk;
	tsm_station_model tsm_station_model_inst (.i_core_clk(clk),
		.o_start_req(st), .o_manual_sw(man));
	tsm_station_mux tsm_station_mux_inst (.i_core_clk(clk), .i_resetn(rstn),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa),
		.i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
		.i_start_req(st), .i_manual_sw(man), .i_instr_count(24'h123456),
		.i_long_data(24'h0), .i_analog_sel(asel), .o_station_enable(en),
		.o_long_data(ld), .o_long_strobe(strb), .o_analog_connect(ana),
		.o_short_reg(sr));
	task chk(input string n, input [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input [11:0] a, input w, input [31:0] d);
		psel <= 1; pen <= 0; pw <= w; pa <= a; pwd <= d;
		@(posedge clk) pen <= 1;
		@(posedge clk) while (rdy !== 1'b1) @(posedge clk);
		q = prd;
		qe = err;
		psel <= 0; pen <= 0;
		@(posedge clk);
	endtask
	task give_verdict;
		if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin #100000; failures++; give_verdict; end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1;
		@(posedge clk) apb(`TSM_ADDR_CTRL, 0, 0);
		chk("ctrl0", q, 32'h0);
		tsm_station_model_inst.o_manual_sw <= 4'h8;
		for (k = 1; k < 4; k++) tsm_station_model_inst.press(k);
		repeat (4) @(posedge clk);
		apb(`TSM_ADDR_CTRL, 0, 0);
		chk("flags", q, 32'h8E);
		pend = 32'h8E;
		// software pointer runs 4-3-2 over station indices 3..1
		for (k = 3; k > 0; k--) begin
			apb(`TSM_ADDR_CTRL, 0, 0);
			p = 3;
			while (p > 0 && !q[p]) p--;
			chk("order", p, k);
			apb(`TSM_ADDR_SEL, 1, p);
			repeat (3) @(posedge clk);
			pend[k] = 0;
			chk("enable", en, 4'h1 << k);
			chk("analog", ana, 4'h1 << k);
			apb(`TSM_ADDR_CTRL, 0, 0);
			chk("ctrl", q, 32'h1000 | (32'h100 << k) | pend);
		end
		asel <= 1'b0;
		repeat (2) @(posedge clk);
		chk("analog_off", ana, 4'h0);
		asel <= 1'b1;
		apb(`TSM_ADDR_INSTR, 1, 32'hABCDEF);
		chk("long", ld, 24'hABCDEF);
		apb(`TSM_ADDR_INSTR, 0, 0);
		chk("count", q, 32'h123456);
		apb(`TSM_ADDR_SEL, 1, 1);
		chk("same", en, 4'h2);
		apb(`TSM_ADDR_SHORT, 1, 32'hA5A5);
		chk("short", sr, 24'h00A5A5);
		apb(`TSM_ADDR_SHORT, 1, 32'h1001);
		chk("short_clr", sr, 24'h0);
		apb(`TSM_ADDR_CTRL, 1, 32'hFFFF);
		apb(`TSM_ADDR_CTRL, 0, 0);
		chk("keep", q, 32'h1280);
		chk("longkeep", ld, 24'hABCDEF);
		// manual station asks again: one step, then back to auto
		tsm_station_model_inst.press(3);
		repeat (4) @(posedge clk);
		apb(`TSM_ADDR_CTRL, 0, 0);
		chk("manual", q[7:0], 8'h88);
		apb(`TSM_ADDR_SEL, 1, 3);
		apb(`TSM_ADDR_INSTR, 1, 32'h1);
		apb(`TSM_ADDR_CTRL, 0, 0);
		chk("stepped", q, 32'h1880);
		tsm_station_model_inst.o_manual_sw <= 4'h0;
		tsm_station_model_inst.press(3);
		repeat (4) @(posedge clk);
		apb(`TSM_ADDR_CTRL, 0, 0);
		chk("auto", q, 32'h1800);
		apb(12'h010, 0, 0);
		chk("unmapped", {qe, q[30:0]}, 32'h80000000);
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		@(posedge clk) apb(`TSM_ADDR_CTRL, 0, 0);
		chk("reset", {en, q[27:0]}, 32'h0);
		chk("reset_ld", ld, 24'h0);
		give_verdict;
	end
endmodule // tsm_station_mux_tb

// ---- src/tsm_defines.vh ----
// constants for the test station multiplexer
`ifndef TSM_DEFINES_VH
`define TSM_DEFINES_VH

// ============================================================
// register map (byte addresses)
`define TSM_ADDR_CTRL      12'h000
`define TSM_ADDR_SEL       12'h004
`define TSM_ADDR_INSTR     12'h008
`define TSM_ADDR_SHORT     12'h00C
`define TSM_ADDR_W         12

// ============================================================
// station control register fields
`define TSM_NSTA           4
`define TSM_START_LSB      0
`define TSM_MANUAL_LSB     4
`define TSM_ENABLE_LSB     8
`define TSM_VALID_BIT      12
`define TSM_SEL_W          2
`define TSM_LONG_W         24
`define TSM_SHORT_W        24
`define TSM_SHORT_RST      24'h000000
`define TSM_SEL_RST        2'h0

// short register clear command: write 1 to bit 12 (TSM_VALID_BIT); this define is unused
`define TSM_CMD_RST_BIT    0

`endif

// ---- src/tsm_station_mux.v ----
// test station multiplexer with APB register access
//
// Contract
// [R1] start request latched per station until selected
// [R2] software reads station control register after tests
// [R3] software scans start flags with a pointer
// [R4] software writes two-bit address; device holds it
// [R5] held address decodes to one enable line
// [R6] enable clears that station's start flag
// [R7] long data and analog buses routed to selected
// [R8] reselecting same station keeps connection unchanged
// [R9] software skips reload for same station
// [R10] switch-over completes within about 30-40 ms
// [R11] no fixed priority; order follows scan pointer
// [R12] auto/manual switches readable beside start flags
// [R13] manual station runs one instruction per request
// [R14] software copies instruction count to display
// [R15] short register reset leaves control register alone
// [R16] long registers of interrupted station keep contents
// [R17] software reruns manual program to stopping point
// [R18] manual-to-auto station finishes automatically
// [R19] reset clears flags and drives no enable
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tsm_defines.vh"

module tsm_station_mux (
	input  wire                     i_core_clk,
	input  wire                     i_resetn,
	input  wire                     i_psel,
	input  wire                     i_penable,
	input  wire                     i_pwrite,
	input  wire [`TSM_ADDR_W-1:0]   i_paddr,
	input  wire [31:0]              i_pwdata,
	output wire [31:0]              o_prdata,
	output wire                     o_pready,
	output wire                     o_pslverr,
	input  wire [`TSM_NSTA-1:0]     i_start_req,
	input  wire [`TSM_NSTA-1:0]     i_manual_sw,
	input  wire [`TSM_SHORT_W-1:0]  i_instr_count,
	input  wire [`TSM_LONG_W-1:0]   i_long_data,
	input  wire                     i_analog_sel,
	output wire [`TSM_NSTA-1:0]     o_station_enable,
	output wire [`TSM_LONG_W-1:0]   o_long_data,
	output wire [`TSM_NSTA-1:0]     o_long_strobe,
	output wire [`TSM_NSTA-1:0]     o_analog_connect,
	output wire [`TSM_SHORT_W-1:0]  o_short_reg
);

	// ============================================================
	// helpers
	function [`TSM_NSTA-1:0] dec_station;
		input [`TSM_SEL_W-1:0] sel;
		input                  valid;
		begin
			dec_station = valid ?
				(`TSM_NSTA'h1 << sel) : {`TSM_NSTA{1'b0}};
		end
	endfunction

	// ============================================================
	// pin synchronisers: three stages, change accepted when the
	// second and third agree so a bouncing switch counts once
	reg [`TSM_NSTA-1:0] start_s1_reg;
	reg [`TSM_NSTA-1:0] start_s2_reg;
	reg [`TSM_NSTA-1:0] start_s3_reg;
	reg [`TSM_NSTA-1:0] start_lvl_reg;
	reg [`TSM_NSTA-1:0] man_s1_reg;
	reg [`TSM_NSTA-1:0] man_s2_reg;
	reg [`TSM_NSTA-1:0] man_s3_reg;
	reg [`TSM_NSTA-1:0] man_lvl_reg;
	reg [`TSM_NSTA-1:0] start_agree;
	reg [`TSM_NSTA-1:0] man_agree;

	always @* begin
		start_agree = ~(start_s2_reg ^ start_s3_reg);
		man_agree   = ~(man_s2_reg ^ man_s3_reg);
	end

	always @(posedge i_core_clk) begin
		if (!i_resetn) begin
			start_s1_reg  <= {`TSM_NSTA{1'b0}};
			start_s2_reg  <= {`TSM_NSTA{1'b0}};
			start_s3_reg  <= {`TSM_NSTA{1'b0}};
			start_lvl_reg <= {`TSM_NSTA{1'b0}};
			man_s1_reg    <= {`TSM_NSTA{1'b0}};
			man_s2_reg    <= {`TSM_NSTA{1'b0}};
			man_s3_reg    <= {`TSM_NSTA{1'b0}};
			man_lvl_reg   <= {`TSM_NSTA{1'b0}};
		end else begin
			start_s1_reg  <= i_start_req;
			start_s2_reg  <= start_s1_reg;
			start_s3_reg  <= start_s2_reg;
			start_lvl_reg <= (start_agree & start_s3_reg) |
				(~start_agree & start_lvl_reg);
			man_s1_reg    <= i_manual_sw;
			man_s2_reg    <= man_s1_reg;
			man_s3_reg    <= man_s2_reg;
			man_lvl_reg   <= (man_agree & man_s3_reg) |
				(~man_agree & man_lvl_reg);
		end
	end

	// ============================================================
	// apb decode; zero wait states, unmapped reads zero + error
	wire acc    = i_psel & i_penable;
	wire wr     = acc & i_pwrite;
	wire hit_ct = (i_paddr == `TSM_ADDR_CTRL);
	wire hit_sl = (i_paddr == `TSM_ADDR_SEL);
	wire hit_in = (i_paddr == `TSM_ADDR_INSTR);
	wire hit_sh = (i_paddr == `TSM_ADDR_SHORT);
	wire mapped = hit_ct | hit_sl | hit_in | hit_sh;

	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~mapped;

	// ============================================================
	// station control register
	reg [`TSM_NSTA-1:0]   start_flag_reg;
	reg [`TSM_NSTA-1:0]   start_prev_reg;
	reg [`TSM_SEL_W-1:0]  sel_reg;
	reg                   sel_valid_reg;
	reg [`TSM_SHORT_W-1:0] short_reg;
	reg [`TSM_LONG_W-1:0] long_data_reg;
	reg [`TSM_NSTA-1:0]   long_strobe_reg;
	reg [31:0]            rdata_reg;
	reg [`TSM_NSTA-1:0]   enable_reg;
	reg [`TSM_NSTA-1:0]   analog_reg;

	wire [`TSM_NSTA-1:0] rise = start_lvl_reg & ~start_prev_reg;
	wire [`TSM_NSTA-1:0] en_now = dec_station(sel_reg, sel_valid_reg);

	always @(posedge i_core_clk) begin
		if (!i_resetn) begin
			start_flag_reg <= {`TSM_NSTA{1'b0}}; // see [R19]
			start_prev_reg <= {`TSM_NSTA{1'b0}};
			sel_reg        <= `TSM_SEL_RST;
			sel_valid_reg  <= 1'b0; // see [R19]
		end else begin
			start_prev_reg <= start_lvl_reg;
			// a new request wins over the clear by the enable
			start_flag_reg <= (start_flag_reg & ~en_now) | rise; // see [R1] see [R6]
			if (wr && hit_sl) begin
				// rewriting the same address changes nothing visible
				sel_reg       <= i_pwdata[`TSM_SEL_W-1:0]; // see [R4] see [R8]
				sel_valid_reg <= 1'b1;
			end
		end
	end

	// enables come from a flop so station lines never glitch
	always @(posedge i_core_clk) begin
		if (!i_resetn) begin
			enable_reg <= {`TSM_NSTA{1'b0}};
			analog_reg <= {`TSM_NSTA{1'b0}};
		end else begin
			enable_reg <= en_now; // see [R5]
			analog_reg <= en_now & {`TSM_NSTA{i_analog_sel}}; // see [R7]
		end
	end

	// ============================================================
	// short register: software clear never touches the control
	// register; long data stays latched at the station side
	always @(posedge i_core_clk) begin
		if (!i_resetn) begin
			short_reg       <= `TSM_SHORT_RST;
			long_data_reg   <= {`TSM_LONG_W{1'b0}};
			long_strobe_reg <= {`TSM_NSTA{1'b0}};
		end else begin
			long_strobe_reg <= {`TSM_NSTA{1'b0}};
			if (wr && hit_sh) begin
				if (i_pwdata[`TSM_VALID_BIT])
					short_reg <= `TSM_SHORT_RST; // see [R15]
				else
					short_reg <= i_pwdata[`TSM_SHORT_W-1:0];
			end
			if (wr && hit_in) begin
				// long data written only toward the enabled station,
				// others keep their contents
				long_data_reg   <= i_pwdata[`TSM_LONG_W-1:0]; // see [R16]
				long_strobe_reg <= en_now; // see [R7]
			end
		end
	end

	// ============================================================
	// read data
	reg [31:0] rmux;
	always @* begin
		rmux = 32'h00000000;
		if (hit_ct) begin
			rmux[`TSM_START_LSB +: `TSM_NSTA]  = start_flag_reg;
			rmux[`TSM_MANUAL_LSB +: `TSM_NSTA] = man_lvl_reg; // see [R12]
			rmux[`TSM_ENABLE_LSB +: `TSM_NSTA] = enable_reg;
			rmux[`TSM_VALID_BIT]               = sel_valid_reg;
		end else if (hit_sl) begin
			rmux[`TSM_SEL_W-1:0] = sel_reg;
		end else if (hit_in) begin
			rmux[`TSM_SHORT_W-1:0] = i_instr_count;
		end else if (hit_sh) begin
			rmux[`TSM_SHORT_W-1:0] = short_reg;
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_resetn)
			rdata_reg <= 32'h00000000;
		else if (i_psel && !i_penable && !i_pwrite)
			rdata_reg <= rmux;
	end

	assign o_prdata         = rdata_reg;
	assign o_station_enable = enable_reg;
	assign o_analog_connect = analog_reg;
	assign o_long_data      = long_data_reg;
	assign o_long_strobe    = long_strobe_reg;
	assign o_short_reg      = short_reg;

	wire unused_ok = &{1'b0, i_long_data};

endmodule // tsm_station_mux
